// *** logic/rtcas_cfg.svh ***
// Purpose: constants of the clock, alarm and stopwatch register block
// Assumes: 125 MHz core clock, 32-bit AXI4-Lite register bus
// Notes:   byte offsets, field positions, reset values, rates
`ifndef RTCAS_CFG_SVH
`define RTCAS_CFG_SVH

`define RTCAS_CLK_HZ        125000000
`define RTCAS_DIV_HZ        256
`define RTCAS_SW_HZ         100

`define RTCAS_OFF_CTL       8'h00
`define RTCAS_OFF_ALM_SEC   8'h04
`define RTCAS_OFF_ALM_HM    8'h08
`define RTCAS_OFF_SW        8'h0C
`define RTCAS_OFF_SEC       8'h10
`define RTCAS_OFF_HM        8'h14

`define RTCAS_CTL_RUN       0
`define RTCAS_CTL_RST       1
`define RTCAS_CTL_ADJ       2
`define RTCAS_CTL_24H       4
`define RTCAS_CTL_HOLD      5
`define RTCAS_CTL_BUSY      6
`define RTCAS_SW_RUN        0
`define RTCAS_SW_CLR        4
`define RTCAS_PM_BIT        14

`define RTCAS_HOUR_RST      6'h12
`define RTCAS_SEC_MAX       7'h59
`define RTCAS_SEC_HALF      7'h30
`define RTCAS_HOUR_11       6'h11
`define RTCAS_HOUR_12       6'h12
`define RTCAS_HOUR_23       6'h23
`define RTCAS_HOUR_01       6'h01
`define RTCAS_DIV_LAST      8'hFF
`define RTCAS_SW_LAST       8'h99

`define RTCAS_RESP_OKAY     2'h0
`define RTCAS_RESP_SLVERR   2'h2

`endif

// *** logic/rtcas_pkg.sv ***
// Purpose: types of the clock, alarm and stopwatch register block
// Assumes: constants come from rtcas_cfg.svh
// Notes:   all state of each module is one packed struct
package rtcas_pkg;

  typedef enum logic [1:0]
  {
    WR_IDLE = 2'b01,
    WR_RESP = 2'b10
  } rtcas_wr_t;

  typedef struct packed {
    logic        t256;
    logic        t100;
    logic [31:0] cnt256;
    logic [31:0] cnt100;
  } rtcas_tick_t;

  typedef struct packed {
    logic        run;
    logic        rstCmd;
    logic        adj;
    logic        hold;
    logic        mode24;
    logic        busy;
    logic        secPend;
    logic [7:0]  div;
    logic [6:0]  sec;
    logic        pm;
    logic [5:0]  hour;
    logic [6:0]  min;
    logic [6:0]  almSec;
    logic        almPm;
    logic [5:0]  almHour;
    logic [6:0]  almMin;
    logic        almMatch;
    logic        alarm;
    logic        swRunReq;
    logic        sw_run_a;
    logic [7:0]  sw;
    rtcas_wr_t   wph;
    logic        awHeld;
    logic        wHeld;
    logic        awReady;
    logic        wReady;
    logic [7:0]  awAddr;
    logic [31:0] wData;
    logic [3:0]  wStrb;
    logic        bValid;
    logic [1:0]  bResp;
    logic        arReady;
    logic        rValid;
    logic [1:0]  rResp;
    logic [31:0] rData;
  } rtcas_state_t;

endpackage : rtcas_pkg

// *** logic/rtcas_tick.sv ***
// Purpose: one-cycle enables at the divider and stopwatch rates
// Assumes: DIV_CYC and SW_CYC are core clock cycles per period
// Notes:   both pulses come straight from flip-flops
`timescale 1ns/100ps
`include "rtcas_cfg.svh"
module rtcas_tick #(
  parameter int unsigned DIV_CYC = `RTCAS_CLK_HZ / `RTCAS_DIV_HZ,
  parameter int unsigned SW_CYC  = `RTCAS_CLK_HZ / `RTCAS_SW_HZ
) (
  input  wire logic core_clk,
  input  wire logic nrst,
  output logic      tick256,
  output logic      tick100
);
  import rtcas_pkg::*;

  rtcas_tick_t s_q;
  rtcas_tick_t s_d;

  always_comb
  begin
    s_d      = s_q;
    s_d.t256 = 1'b0;
    s_d.t100 = 1'b0;
    if (s_q.cnt256 >= DIV_CYC - 1)
    begin
      s_d.cnt256 = 32'h0000_0000;
      s_d.t256   = 1'b1;
    end
    else
    begin
      s_d.cnt256 = s_q.cnt256 + 32'h0000_0001;
    end
    if (s_q.cnt100 >= SW_CYC - 1)
    begin
      s_d.cnt100 = 32'h0000_0000;
      s_d.t100   = 1'b1;
    end
    else
    begin
      s_d.cnt100 = s_q.cnt100 + 32'h0000_0001;
    end
  end

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign tick256 = s_q.t256;
  assign tick100 = s_q.t100;

endmodule : rtcas_tick

// *** logic/rtcas_top.sv ***
// Purpose: time counter, alarm and stopwatch registers on AXI4-Lite
// Assumes: single 125 MHz clock, inputs synchronous to it
// Notes:   alarmEvent is a one-cycle pulse
//
// How it works
// - counter reset command bit clears itself once the reset is done
// - run bit zero freezes time counter, one resumes from held value
// - second alarm: tens in 14:12, units in 11:8, BCD 00-59
// - alarm PM bit 14 counts in 12-hour mode only
// - alarm hour: 2-bit tens, 4-bit units, 1-12 or 0-23
// - alarm minute: tens in 6:4, units in 3:0, BCD 0-59
// - stopwatch tenths in 15:12, hundredths in 11:8, read-only
// - stopwatch clear sets count to 00, run state taken from bit 0 of the same write, reads zero
// - stopwatch run zero holds count, one resumes from it
// - stopwatch stops on its own tick, may advance once more
// - seconds field read/write, 3-bit tens, 4-bit units, 0-59
// - low seconds byte shows divider stages, 128 Hz at bit 0
// - counter reset command clears all eight divider stages
// - hour PM bit 14 read/write in 12-hour mode
// - 24-hour mode: PM reads zero, ignores one, clears next hour
// - mode bit one selects 24-hour, change leaves hour untouched
// - busy rises on count-up or correction, lasts 1/256 second
// - counter reset command clears divider, adjust and hold bits
// - alarm fires 1/256 second after full time match
`timescale 1ns/100ps
`include "rtcas_cfg.svh"
module rtcas_top #(
  parameter int unsigned DIV_CYC = `RTCAS_CLK_HZ / `RTCAS_DIV_HZ,
  parameter int unsigned SW_CYC  = `RTCAS_CLK_HZ / `RTCAS_SW_HZ
) (
  input  wire logic        core_clk,
  input  wire logic        nrst,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic             alarmEvent
);
  import rtcas_pkg::*;

  rtcas_state_t s_q;
  rtcas_state_t s_d;
  logic         tick256;
  logic         tick100;

  rtcas_tick #(
    .DIV_CYC (DIV_CYC),
    .SW_CYC  (SW_CYC)
  ) u_tick (
    .core_clk (core_clk),
    .nrst     (nrst),
    .tick256  (tick256),
    .tick100  (tick100)
  );

  // two-digit BCD step, low digit wraps at nine
  function automatic logic [7:0] bcdInc(input logic [7:0] v);
    if (v[3:0] == 4'h9)
    begin
      return {v[7:4] + 4'h1, 4'h0};
    end
    return {v[7:4], v[3:0] + 4'h1};
  endfunction : bcdInc

  // seconds or minutes step, carry in bit 7
  function automatic logic [7:0] inc60(input logic [6:0] v);
    logic [7:0] nx;
    nx = bcdInc({1'b0, v});
    if (v == `RTCAS_SEC_MAX)
    begin
      return 8'h80;
    end
    return {1'b0, nx[6:0]};
  endfunction : inc60

  // hour step, pm in bit 6
  function automatic logic [6:0] hourInc(input logic [5:0] h,
                                         input logic       pm,
                                         input logic       m24);
    logic [7:0] nx;
    nx = bcdInc({2'b00, h});
    if (m24)
    begin
      if (h == `RTCAS_HOUR_23)
      begin
        return 7'h00;
      end
      return {1'b0, nx[5:0]};
    end
    if (h == `RTCAS_HOUR_12)
    begin
      return {pm, `RTCAS_HOUR_01};
    end
    if (h == `RTCAS_HOUR_11)
    begin
      return {~pm, `RTCAS_HOUR_12};
    end
    return {pm, nx[5:0]};
  endfunction : hourInc

  // merge 16-bit register with byte enables
  function automatic logic [15:0] merge(input logic [15:0] cur,
                                        input logic [31:0] wd,
                                        input logic [3:0]  st);
    return {st[1] ? wd[15:8] : cur[15:8], st[0] ? wd[7:0] : cur[7:0]};
  endfunction : merge

  function automatic logic [15:0] readReg(input rtcas_state_t s,
                                          input logic [7:0]   a);
    unique case (a)
      `RTCAS_OFF_CTL:
        return {9'h000, s.busy, s.hold, s.mode24, 1'b0, s.adj,
                s.rstCmd, s.run};
      `RTCAS_OFF_ALM_SEC:
        return {1'b0, s.almSec, 8'h00};
      `RTCAS_OFF_ALM_HM:
        return {1'b0, s.almPm, s.almHour, 1'b0, s.almMin};
      `RTCAS_OFF_SW:
        return {s.sw, 7'h00, s.swRunReq};
      `RTCAS_OFF_SEC:
        return {1'b0, s.sec, s.div};
      `RTCAS_OFF_HM:
        return {1'b0, s.pm & ~s.mode24, s.hour, 1'b0, s.min};
      default:
        return 16'h0000;
    endcase
  endfunction : readReg

  function automatic logic mapped(input logic [7:0] a);
    return (a[1:0] == 2'b00) && (a <= `RTCAS_OFF_HM);
  endfunction : mapped

  always_comb
  begin
    logic [7:0]  sInc;
    logic [7:0]  mInc;
    logic [6:0]  hInc;
    logic        match;
    logic [15:0] wv;
    sInc       = 8'h00;
    mInc       = 8'h00;
    hInc       = 7'h00;
    wv         = 16'h0000;
    s_d        = s_q;
    s_d.alarm  = 1'b0;
    match      = (s_q.sec == s_q.almSec) && (s_q.min == s_q.almMin) &&
                 (s_q.hour == s_q.almHour) &&
                 (s_q.mode24 || (s_q.pm == s_q.almPm));

    if (tick256)
    begin
      s_d.busy = 1'b0;
      s_d.almMatch = match;
      s_d.alarm = match && !s_q.almMatch;
      if (s_q.run)
      begin
        s_d.div = s_q.div + 8'h01;
        if (s_q.div == `RTCAS_DIV_LAST)
        begin
          s_d.secPend = 1'b1;
        end
      end
    end

    if (s_q.secPend && !s_q.hold)
    begin
      s_d.secPend = 1'b0;
      s_d.busy    = 1'b1;
      sInc        = inc60(s_q.sec);
      s_d.sec     = sInc[6:0];
      if (sInc[7])
      begin
        mInc    = inc60(s_q.min);
        s_d.min = mInc[6:0];
        if (mInc[7])
        begin
          hInc     = hourInc(s_q.hour, s_q.pm, s_q.mode24);
          s_d.hour = hInc[5:0];
          s_d.pm   = hInc[6];
        end
      end
    end
    else if (s_q.adj && tick256)
    begin
      s_d.adj  = 1'b0;
      s_d.busy = 1'b1;
      s_d.sec  = 7'h00;
      if (s_q.sec >= `RTCAS_SEC_HALF)
      begin
        mInc    = inc60(s_q.min);
        s_d.min = mInc[6:0];
        if (mInc[7])
        begin
          hInc     = hourInc(s_q.hour, s_q.pm, s_q.mode24);
          s_d.hour = hInc[5:0];
          s_d.pm   = hInc[6];
        end
      end
    end

    if (s_q.rstCmd)
    begin
      s_d.div     = 8'h00;
      s_d.adj     = 1'b0;
      s_d.hold    = 1'b0;
      s_d.secPend = 1'b0;
      s_d.rstCmd  = 1'b0;
    end

    if (tick100)
    begin
      s_d.sw_run_a = s_q.swRunReq;
      if (s_q.sw_run_a)
      begin
        s_d.sw = (s_q.sw == `RTCAS_SW_LAST) ? 8'h00 : bcdInc(s_q.sw);
      end
    end

    if (s_axi_awvalid && s_q.awReady)
    begin
      s_d.awHeld = 1'b1;
      s_d.awAddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_q.wReady)
    begin
      s_d.wHeld = 1'b1;
      s_d.wData = s_axi_wdata;
      s_d.wStrb = s_axi_wstrb;
    end

    unique case (s_q.wph)
      WR_IDLE:
      begin
        if (s_q.awHeld && s_q.wHeld)
        begin
          wv         = merge(readReg(s_q, s_q.awAddr), s_q.wData, s_q.wStrb);
          s_d.awHeld = 1'b0;
          s_d.wHeld  = 1'b0;
          s_d.bValid = 1'b1;
          s_d.bResp  = mapped(s_q.awAddr) ? `RTCAS_RESP_OKAY
                                          : `RTCAS_RESP_SLVERR;
          s_d.wph    = WR_RESP;
          unique case (s_q.awAddr)
            `RTCAS_OFF_CTL:
            begin
              s_d.run    = wv[`RTCAS_CTL_RUN];
              s_d.mode24 = wv[`RTCAS_CTL_24H];
              s_d.hold   = wv[`RTCAS_CTL_HOLD];
              if (s_q.wStrb[0] && wv[`RTCAS_CTL_RST])
              begin
                s_d.rstCmd = 1'b1;
              end
              if (s_q.wStrb[0] && wv[`RTCAS_CTL_ADJ])
              begin
                s_d.adj = 1'b1;
              end
            end
            `RTCAS_OFF_ALM_SEC:
            begin
              s_d.almSec = wv[14:8];
            end
            `RTCAS_OFF_ALM_HM:
            begin
              s_d.almPm   = wv[`RTCAS_PM_BIT];
              s_d.almHour = wv[13:8];
              s_d.almMin  = wv[6:0];
            end
            `RTCAS_OFF_SW:
            begin
              s_d.swRunReq = wv[`RTCAS_SW_RUN];
              if (s_q.wStrb[0] && wv[`RTCAS_SW_CLR])
              begin
                s_d.sw = 8'h00;
              end
            end
            `RTCAS_OFF_SEC:
            begin
              s_d.sec = wv[14:8];
            end
            `RTCAS_OFF_HM:
            begin
              s_d.pm   = wv[`RTCAS_PM_BIT] & ~s_q.mode24;
              s_d.hour = wv[13:8];
              s_d.min  = wv[6:0];
            end
            default:
            begin
              s_d.bResp = `RTCAS_RESP_SLVERR;
            end
          endcase
        end
      end
      WR_RESP:
      begin
        if (s_axi_bready)
        begin
          s_d.bValid = 1'b0;
          s_d.wph    = WR_IDLE;
        end
      end
    endcase
    s_d.awReady = !s_d.awHeld;
    s_d.wReady  = !s_d.wHeld;

    if (s_axi_arvalid && s_q.arReady)
    begin
      s_d.rData   = {16'h0000, readReg(s_q, s_axi_araddr)};
      s_d.rResp   = mapped(s_axi_araddr) ? `RTCAS_RESP_OKAY
                                         : `RTCAS_RESP_SLVERR;
      s_d.rValid  = 1'b1;
      s_d.arReady = 1'b0;
    end
    else if (s_q.rValid && s_axi_rready)
    begin
      s_d.rValid  = 1'b0;
      s_d.arReady = 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      s_q         <= '0;
      s_q.hour    <= `RTCAS_HOUR_RST;
      s_q.wph     <= WR_IDLE;
      s_q.awReady <= 1'b1;
      s_q.wReady  <= 1'b1;
      s_q.arReady <= 1'b1;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign s_axi_awready = s_q.awReady;
  assign s_axi_wready  = s_q.wReady;
  assign s_axi_bvalid  = s_q.bValid;
  assign s_axi_bresp   = s_q.bResp;
  assign s_axi_arready = s_q.arReady;
  assign s_axi_rvalid  = s_q.rValid;
  assign s_axi_rdata   = s_q.rData;
  assign s_axi_rresp   = s_q.rResp;
  assign alarmEvent    = s_q.alarm;

endmodule : rtcas_top

// *** test/rtcas_checker.sv ***
// Purpose: bus timing and read field checks of rtcas_top
// Assumes: sees only the top ports
// Notes:   read address captured at the address handshake
`timescale 1ns/100ps
module rtcas_checker (
  input wire logic        core_clk,
  input wire logic        nrst,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic [7:0]  s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        alarmEvent
);
  logic [7:0] rdA_q;

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
      rdA_q <= 8'h00;
    else if (s_axi_arvalid && s_axi_arready)
      rdA_q <= s_axi_araddr;
  end

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!nrst);

  sequence s_wrPair;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_rdTake;
    s_axi_arvalid && s_axi_arready;
  endsequence
  sequence s_rd(logic [7:0] a);
    s_axi_rvalid && rdA_q == a;
  endsequence

  property p_wrResp;
    s_wrPair |-> ##2 s_axi_bvalid;
  endproperty
  property p_rdResp;
    s_rdTake |=> s_axi_rvalid && !s_axi_arready;
  endproperty
  property p_alarmPulse;
    alarmEvent |=> !alarmEvent;
  endproperty
  property p_hiZero;
    s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000;
  endproperty
  property p_almSec;
    s_rd(8'h04) |-> !s_axi_rdata[15] && s_axi_rdata[7:0] == 8'h00;
  endproperty
  property p_almHm;
    s_rd(8'h08) |-> !s_axi_rdata[15] && !s_axi_rdata[7];
  endproperty
  property p_swRd;
    s_rd(8'h0C) |-> s_axi_rdata[7:1] == 7'h00;
  endproperty
  property p_secRd;
    s_rd(8'h10) |-> !s_axi_rdata[15] && s_axi_rdata[14:12] <= 3'h5
      && s_axi_rdata[11:8] <= 4'h9;
  endproperty
  property p_ctlRd;
    s_rd(8'h00) |-> s_axi_rdata[15:7] == 9'h000 && !s_axi_rdata[3];
  endproperty

  a_wrResp: assert property (p_wrResp)
    else $error("write response late");
  a_rdResp: assert property (p_rdResp)
    else $error("read response late");
  a_alarmPulse: assert property (p_alarmPulse)
    else $error("alarm event longer than one cycle");
  a_hiZero: assert property (p_hiZero)
    else $error("upper read half not zero");
  a_almSec: assert property (p_almSec)
    else $error("second alarm reserved bits set");
  a_almHm: assert property (p_almHm)
    else $error("hour minute alarm reserved bits set");
  a_swRd: assert property (p_swRd)
    else $error("stopwatch clear or reserved bits read one");
  a_secRd: assert property (p_secRd)
    else $error("seconds field out of range");
  a_ctlRd: assert property (p_ctlRd)
    else $error("control reserved bits set");
endmodule : rtcas_checker

bind rtcas_top rtcas_checker u_chk (.core_clk, .nrst, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
  .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
  .s_axi_rvalid, .alarmEvent);

// *** test/rtcas_bench.sv ***
// Purpose: register bench of rtcas_top
// Assumes: DIV_CYC 8, SW_CYC 5, one second is 2048 cycles
// Notes:   AXI4-Lite master tasks
`timescale 1ns/100ps
`include "rtcas_cfg.svh"
`define CHK(nm, ex, gt) check(nm, 32'(ex), 32'(gt));
module rtcas_bench;
  logic        core_clk = 1'b0;
  logic        nrst = 1'b0;
  logic [7:0]  awAddr = 8'h00;
  logic [7:0]  arAddr = 8'h00;
  logic [31:0] wData = 32'h0;
  logic        awValid = 1'b0;
  logic        wValid = 1'b0;
  logic        bReady = 1'b0;
  logic        arValid = 1'b0;
  logic        rReady = 1'b0;
  logic        awReady, wReady, bValid, arReady, rValid, alarmEvent;
  logic [1:0]  bResp, rResp, rs;
  logic [31:0] rData, v, w;
  int          n_mismatch = 0;
  int          n_compared = 0;

  rtcas_top #(.DIV_CYC(8), .SW_CYC(5)) DUT (
    .core_clk(core_clk), .nrst(nrst),
    .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid),
    .s_axi_awready(awReady), .s_axi_wdata(wData),
    .s_axi_wstrb(4'h3), .s_axi_wvalid(wValid),
    .s_axi_wready(wReady), .s_axi_bresp(bResp),
    .s_axi_bvalid(bValid), .s_axi_bready(bReady),
    .s_axi_araddr(arAddr), .s_axi_arvalid(arValid),
    .s_axi_arready(arReady), .s_axi_rdata(rData),
    .s_axi_rresp(rResp), .s_axi_rvalid(rValid),
    .s_axi_rready(rReady), .alarmEvent(alarmEvent));

  initial
  begin
    forever #4 core_clk = ~core_clk;
  end

  task automatic wrap_up;
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : wrap_up

  task automatic check(input string nm, input logic [31:0] ex, gt);
    n_compared++;
    if (gt !== ex)
    begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", nm, ex, gt);
    end
  endtask : check

  task automatic axWr(input logic [7:0] a, input logic [15:0] d);
    int n;
    n = 0;
    @(posedge core_clk);
    awAddr <= a;
    wData <= {16'h0000, d};
    awValid <= 1'b1;
    wValid <= 1'b1;
    bReady <= 1'b1;
    do
    begin
      @(posedge core_clk);
      n++;
      if (awReady) awValid <= 1'b0;
      if (wReady) wValid <= 1'b0;
    end
    while (bValid !== 1'b1 && n < 50);
    bReady <= 1'b0;
    rs = bResp;
    if (bValid !== 1'b1)
    begin
      n_mismatch++;
      wrap_up();
    end
  endtask : axWr

  task automatic axRd(input logic [7:0] a, output logic [31:0] d);
    int n;
    n = 0;
    @(posedge core_clk);
    arAddr <= a;
    arValid <= 1'b1;
    rReady <= 1'b1;
    do
    begin
      @(posedge core_clk);
      n++;
      if (arReady) arValid <= 1'b0;
    end
    while (rValid !== 1'b1 && n < 50);
    rReady <= 1'b0;
    d = rData;
    rs = rResp;
    if (rValid !== 1'b1)
    begin
      n_mismatch++;
      wrap_up();
    end
  endtask : axRd

  initial
  begin
    repeat (100000) @(posedge core_clk);
    n_mismatch++;
    wrap_up();
  end

  initial
  begin
    int n;
    repeat (10) @(posedge core_clk);
    nrst <= 1'b1;
    for (int i = 0; i < 6; i++)
    begin
      axRd(8'(4 * i), v);
      `CHK("reset", (i == 5) ? 32'h1200 : 32'h0, v)
    end
    axRd(8'h18, v);
    `CHK("rdresp", `RTCAS_RESP_SLVERR, rs)
    axWr(8'h18, 16'hFFFF);
    `CHK("wrresp", `RTCAS_RESP_SLVERR, rs)
    axWr(`RTCAS_OFF_ALM_SEC, 16'hD9FF);
    axRd(`RTCAS_OFF_ALM_SEC, v);
    `CHK("almsec", 32'h5900, v)
    axWr(`RTCAS_OFF_ALM_HM, 16'hD1D9);
    axRd(`RTCAS_OFF_ALM_HM, v);
    `CHK("almhm", 32'h5159, v)
    axWr(`RTCAS_OFF_SEC, 16'h5800);
    axWr(`RTCAS_OFF_CTL, 16'h0001);
    repeat (2100) @(posedge core_clk);
    axRd(`RTCAS_OFF_SEC, v);
    `CHK("sec", 7'h59, v[14:8])
    axWr(`RTCAS_OFF_CTL, 16'h0000);
    axRd(`RTCAS_OFF_SEC, v);
    repeat (300) @(posedge core_clk);
    axRd(`RTCAS_OFF_SEC, w);
    `CHK("stopped", v, w)
    axWr(`RTCAS_OFF_CTL, 16'h0001);
    repeat (2100) @(posedge core_clk);
    axRd(`RTCAS_OFF_HM, v);
    `CHK("resumed", 32'h1201, v)
    n = 0;
    do
    begin
      axRd(`RTCAS_OFF_SEC, v);
      axRd(`RTCAS_OFF_SEC, w);
      n++;
    end
    while (v !== w && n < 8);
    `CHK("divtwice", v, w)
    axWr(`RTCAS_OFF_CTL, 16'h0022);
    axRd(`RTCAS_OFF_CTL, v);
    `CHK("rstcmd", 32'h0, v)
    axRd(`RTCAS_OFF_SEC, v);
    `CHK("divider", 8'h00, v[7:0])
    axWr(`RTCAS_OFF_HM, 16'h5130);
    axRd(`RTCAS_OFF_HM, v);
    `CHK("pm12", 32'h5130, v)
    axWr(`RTCAS_OFF_HM, 16'h1130);
    axWr(`RTCAS_OFF_CTL, 16'h0010);
    axRd(`RTCAS_OFF_HM, v);
    `CHK("mode24", 32'h1130, v)
    axWr(`RTCAS_OFF_HM, 16'h5230);
    axRd(`RTCAS_OFF_HM, v);
    `CHK("pm24", 32'h1230, v)
    axWr(`RTCAS_OFF_CTL, 16'h0000);
    axWr(`RTCAS_OFF_HM, 16'h1159);
    axWr(`RTCAS_OFF_SEC, 16'h5900);
    axWr(`RTCAS_OFF_ALM_HM, 16'h5200);
    axWr(`RTCAS_OFF_ALM_SEC, 16'h0000);
    axWr(`RTCAS_OFF_CTL, 16'h0001);
    n = 0;
    while (alarmEvent !== 1'b1 && n < 2400)
    begin
      @(posedge core_clk);
      n++;
    end
    `CHK("alarm", 1'b1, alarmEvent)
    axRd(`RTCAS_OFF_HM, v);
    `CHK("noon", 32'h5200, v)
    axWr(`RTCAS_OFF_SW, 16'h0001);
    repeat (60) @(posedge core_clk);
    axWr(`RTCAS_OFF_SW, 16'h0000);
    repeat (10) @(posedge core_clk);
    axRd(`RTCAS_OFF_SW, v);
    repeat (50) @(posedge core_clk);
    axRd(`RTCAS_OFF_SW, w);
    `CHK("swhold", v, w)
    `CHK("swcnt", 1'b1, v[15:8] != 8'h00)
    axWr(`RTCAS_OFF_SW, 16'h0001);
    repeat (30) @(posedge core_clk);
    axRd(`RTCAS_OFF_SW, w);
    `CHK("swresume", 1'b1, w[15:8] > v[15:8])
    axWr(`RTCAS_OFF_SW, 16'h0011);
    axRd(`RTCAS_OFF_SW, w);
    `CHK("swclrrun", 1'b1, w[15:8] <= 8'h01)
    n = 0;
    do
    begin
      axRd(`RTCAS_OFF_SW, v);
      axRd(`RTCAS_OFF_SW, w);
      n++;
    end
    while (v !== w && n < 8);
    `CHK("swtwice", v, w)
    `CHK("swbcd", 1'b1, v[11:8] <= 4'h9)
    axWr(`RTCAS_OFF_SW, 16'h0000);
    repeat (10) @(posedge core_clk);
    axWr(`RTCAS_OFF_SW, 16'h0010);
    axRd(`RTCAS_OFF_SW, w);
    `CHK("swclridle", 32'h0, w)
    wrap_up();
  end
endmodule : rtcas_bench
